// ---- bench/fetch_model.sv ----
/* fetch path model: hands words to the decoder, one a cycle.
   assumes calls start right after a rising edge of clk_in. */
`timescale 1ns/1ps
`default_nettype none
module fetch_model (
  input  wire logic   clk_in,
  output logic        valid_out,
  output logic [23:0] word_out
);
  initial begin
    valid_out = 1'b0;
    word_out  = 24'h00_0000;
  end
  task send(input logic [23:0] w);
    valid_out <= 1'b1;
    word_out  <= w;
    @(posedge clk_in);
  endtask : send
  // released word shows the inverse, never the stale value
  task idle();
    valid_out <= 1'b0;
    word_out  <= ~word_out;
    @(posedge clk_in);
  endtask : idle
endmodule : fetch_model
`default_nettype wire

// ---- bench/operand_decode_assertions.sv ----
/* checker for the operand field decoder.
   bound to the decoder top, sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module operand_decode_assertions
  import operand_decode_pkg::*;
(
  input wire logic clk_in, rst_in, instr_valid_in, dec_valid_out,
  input wire logic exec_enable_out, illegal_out, writeback_en_out,
  input wire logic x_prefetch_en_out,
  input wire instr_class_t instr_class_out,
  input wire logic [1:0]  op_size_out,
  input wire logic [22:0] immediate_out,
  input wire logic [15:0] bit_mask_out,
  input wire logic [3:0]  writeback_pointer_out, x_prefetch_pointer_out,
  input wire logic [3:0]  x_prefetch_dest_out
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire logic ok = dec_valid_out && !illegal_out;
  AST_SRC: assert property (dec_valid_out |-> $past(instr_valid_in))
    else $error("decode pulse without a taken word");
  AST_EVEN: assert property (ok && instr_class_out == CLS_GOTO |->
    !immediate_out[0]) else $error("odd program address accepted");
  AST_LIT: assert property (ok && op_size_out == SZ_BYTE &&
    instr_class_out == CLS_TEN_BIT_IMMEDIATE |-> immediate_out <= 23'h00ff)
    else $error("byte literal above limit accepted");
  AST_SIZE: assert property (ok |-> op_size_out != 2'h3)
    else $error("reserved size accepted");
  AST_WB: assert property (ok && writeback_en_out |->
    writeback_pointer_out == WB_REG) else $error("bad write-back pointer");
  AST_XPF: assert property (ok && x_prefetch_en_out |->
    x_prefetch_pointer_out[3:1] == 3'h4 && x_prefetch_dest_out[3:2] == 2'h1)
    else $error("bad x prefetch selects");
  AST_MASK: assert property (ok && instr_class_out == CLS_BIT |->
    $onehot(bit_mask_out)) else $error("bit mask not one-hot");
  AST_EXEC: assert property (exec_enable_out |-> dec_valid_out)
    else $error("execute without decode");
  cover property (dec_valid_out && illegal_out);
  cover property (ok && instr_class_out == CLS_GOTO);
  cover property (ok && writeback_en_out);
endmodule : operand_decode_assertions
`default_nettype wire

// ---- bench/testbench.sv ----
/* self-checking bench for the operand field decoder.
   assumes the fetch model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected %0t value mismatch", $time); end end
module testbench;
  import operand_decode_pkg::*;
  logic clk_in = 0, rst_in = 1, psel = 0, penable = 0, pwrite = 0, ev;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, rd;
  logic [4:0] awe = 5'h00, af = 5'h00;
  logic stz = 1'b0;
  logic [3:0] dwe = 4'h0, df = 4'h0;
  logic [25:0] q[$], e;
  int mismatches = 0, checks = 0;
  logic [9:0] lit; logic [1:0] sz; logic [3:0] r, p; logic [22:0] g, a;
  wire logic iv, dv, ill, pready, perr;
  wire logic [23:0] iw; wire logic [31:0] prdata; wire logic [22:0] imm;
  wire logic [15:0] bm; wire logic [12:0] fa; wire logic [3:0] xd, dflags;
  wire logic [4:0] aflags;
  fetch_model fm (.clk_in(clk_in), .valid_out(iv), .word_out(iw));
  operand_field_decoder dut (.clk_in(clk_in), .rst_in(rst_in),
    .instr_valid_in(iv), .instr_word_in(iw), .arith_flag_we_in(awe),
    .arith_flag_in(af), .sticky_zero_in(stz), .dsp_flag_we_in(dwe),
    .dsp_flag_in(df), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pready_out(pready), .prdata_out(prdata), .pslverr_out(perr),
    .dec_valid_out(dv), .exec_enable_out(), .illegal_out(ill),
    .instr_class_out(), .op_size_out(), .acc_select_out(),
    .base_register_out(), .source_operand_out(),
    .destination_operand_out(), .file_addr_out(fa),
    .default_work_register_out(), .immediate_out(imm), .bit_mask_out(bm),
    .x_prefetch_en_out(), .x_prefetch_pointer_out(), .x_prefetch_mod_out(),
    .x_prefetch_indexed_out(), .x_prefetch_dest_out(xd),
    .y_prefetch_en_out(), .y_prefetch_pointer_out(),
    .y_prefetch_mod_out(), .y_prefetch_indexed_out(),
    .y_prefetch_dest_out(), .writeback_en_out(),
    .writeback_post_inc_out(), .writeback_pointer_out(),
    .arith_flags_out(aflags), .dsp_flags_out(dflags));
  // ------------------------------------------------------------
  // tasks and scoreboard
  // ------------------------------------------------------------
  initial forever #4 clk_in = ~clk_in;
  task tally_and_finish();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    psel <= 1; pwrite <= w; paddr <= ad; pwdata <= d; penable <= 0;
    @(posedge clk_in);
    penable <= 1;
    n = 0;
    do begin @(posedge clk_in); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) mismatches++;
    rd = prdata; ev = perr; psel <= 0; penable <= 0;
    @(posedge clk_in);
  endtask : apb
  function logic [22:0] seen(input logic [1:0] s);
    return s == 0 ? imm : s == 1 ? {7'h00, bm} : s == 2 ? {10'h000, fa}
      : {19'h0_0000, xd};
  endfunction : seen
  always @(negedge clk_in) if (dv === 1'b1) begin
    if (q.size() == 0) `CHK(1'b0, 1'b1) else begin
      e = q.pop_front();
      `CHK(ill, e[23])
      if (!e[23]) `CHK(seen(e[25:24]), e[22:0])
    end
  end
  initial begin repeat (20000) @(posedge clk_in); mismatches++;
    tally_and_finish(); end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h661487ef));
    repeat (3) @(posedge clk_in);
    rst_in <= 0;
    @(posedge clk_in);
    apb(0, CTRL_OFS, 0); `CHK(rd[0], CTRL_RESET[0])
    apb(1, CTRL_OFS, 32'h0000_0000);
    apb(0, 8'h0c, 0); `CHK(ev, 1'b1)
    $display("test registers done");
    af <= 5'($urandom); df <= 4'($urandom); awe <= 5'h1f; dwe <= 4'hf;
    @(posedge clk_in); awe <= 0; dwe <= 0;
    @(posedge clk_in);
    `CHK(aflags, af)
    `CHK(dflags, df)
    lit[0] = af[4];
    stz <= 1'b1; af[4] <= 1'b1; awe <= 5'h10;
    @(posedge clk_in); awe <= 0;
    @(posedge clk_in);
    `CHK(aflags[4], lit[0])
    $display("test flags done");
    for (int i = 0; i < 16; i++) begin
      lit = 10'($urandom); sz = 2'($urandom); r = 4'($urandom);
      p = 4'($urandom); a = 23'($urandom); g = 23'($urandom); g[0] = i[0];
      q.push_back({2'h0, sz == 3 || (sz == 1 && lit > 255), 13'h0, lit});
      fm.send({OP_TEN_BIT_IMMEDIATE, sz, lit, r});
      q.push_back({2'h1, 1'b0, 7'h00, 16'h0001 << p});
      fm.send({OP_BIT, p, 8'h00, r});
      q.push_back({2'h2, 1'b0, 10'h000, a[12:0]});
      fm.send({OP_FILE, 3'h0, a[12:0]});
      q.push_back({2'h3, i[2:0] > 5, 19'h0_0000, 4'h4 + a[5:4]});
      fm.send({8'hc2, i[2:0], a[3:0], a[5:4], a[9:6], a[11:10], 1'b1});
      q.push_back({2'h0, i[0], g});
      fm.send({OP_GOTO, g[15:0]});
      fm.send({8'h00, 9'h000, g[22:16]});
    end
    fm.idle();
    for (int n = 0; n < 50 && q.size() > 0; n++) @(posedge clk_in);
    `CHK(q.size(), 0)
    $display("test decode done");
    tally_and_finish();
  end
endmodule : testbench
bind operand_field_decoder operand_decode_assertions chk (.*);
`default_nettype wire

// ---- common/operand_decode_pkg.sv ----
/* Shared constants of the operand field decoder.
   Assumes 24-bit instruction words and a 32-bit APB bus. */
package operand_decode_pkg;

  // --------------------
  // instruction word layout
  // --------------------
  localparam int INSTR_W      = 24;
  localparam int OPC_MSB      = 23;
  localparam int OPC_LSB      = 16;
  localparam int SIZE_MSB     = 15;
  localparam int SIZE_LSB     = 14;
  localparam int FILE_DEFAULT_WORK_REGISTER    = 13;
  localparam int FILE_MSB     = 12;
  localparam int TEN_BIT_IMMEDIATE_MSB    = 13;
  localparam int TEN_BIT_IMMEDIATE_LSB    = 4;
  localparam int BITPOS_MSB   = 15;
  localparam int BITPOS_LSB   = 12;
  localparam int PAIR_MSB     = 15;
  localparam int PAIR_LSB     = 13;
  localparam int XPF_MSB      = 12;
  localparam int XPF_LSB      = 9;
  localparam int XDST_MSB     = 8;
  localparam int XDST_LSB     = 7;
  localparam int YPF_MSB      = 6;
  localparam int YPF_LSB      = 3;
  localparam int YDST_MSB     = 2;
  localparam int YDST_LSB     = 1;
  localparam int AWB_MODE     = 0;
  localparam int SECOND_HI_W  = 7;

  // --------------------
  // opcodes
  // --------------------
  localparam logic [7:0] OP_NOP   = 8'h00;
  localparam logic [7:0] OP_FILE  = 8'h10;
  localparam logic [7:0] OP_TEN_BIT_IMMEDIATE = 8'h20;
  localparam logic [7:0] OP_BIT   = 8'h30;
  localparam logic [7:0] OP_REG3  = 8'h40;
  localparam logic [7:0] OP_DIV   = 8'h50;
  localparam logic [7:0] OP_GOTO  = 8'h60;
  localparam logic [5:0] OP_MAC6  = 6'h30;
  localparam logic [5:0] OP_SQR6  = 6'h31;

  // --------------------
  // operand encodings
  // --------------------
  localparam logic [1:0]  SZ_WORD     = 2'h0;
  localparam logic [1:0]  SZ_BYTE     = 2'h1;
  localparam logic [1:0]  SZ_DOUBLE   = 2'h2;
  localparam logic [9:0]  TEN_BIT_IMMEDIATE_BYTE_MAX = 10'h0FF;
  localparam logic [12:0] FILE_ADDR_MAX  = 13'h1FFF;
  localparam logic [3:0]  DEFAULT_WORK_REGISTER_DEFAULT   = 4'h0;
  localparam logic [3:0]  WB_REG         = 4'hD;
  localparam logic [3:0]  PF_DST_BASE    = 4'h4;
  localparam logic [3:0]  XPF_BASE       = 4'h8;
  localparam logic [3:0]  YPF_BASE       = 4'hA;
  localparam logic [2:0]  PF_MODE_ALT    = 3'h4;

  typedef enum logic [3:0] {
    CLS_NOP, CLS_FILE, CLS_TEN_BIT_IMMEDIATE, CLS_BIT, CLS_REG3,
    CLS_DIV, CLS_GOTO, CLS_MAC, CLS_SQR, CLS_UNKNOWN
  } instr_class_t;

  // --------------------
  // register map and reset values
  // --------------------
  localparam logic [7:0]  CTRL_OFS      = 8'h00;
  localparam logic [7:0]  STATUS_OFS    = 8'h04;
  localparam logic [7:0]  LAST_BAD_OFS  = 8'h08;
  localparam int          CTRL_BLOCK    = 0;
  localparam int          ST_ILLEGAL    = 16;
  localparam logic [0:0]  CTRL_RESET    = 1'h1;
  localparam logic [4:0]  ARITH_RESET   = 5'h00;
  localparam logic [3:0]  DSP_RESET     = 4'h0;

endpackage : operand_decode_pkg

// ---- hw/multiply_pair_decode.sv ----
/*
  Decodes the 3-bit multiply operand field into two working registers,
  for both the distinct-pair and the square forms.
  Assumes the caller says which form the opcode asked for.
*/
`timescale 1ns/1ps
`default_nettype none

module multiply_pair_decode
  import operand_decode_pkg::*;
(
  input  wire logic [2:0] code_in,
  input  wire logic       square_in,
  output logic [3:0]      first_out,
  output logic [3:0]      second_out,
  output logic            illegal_out
);

  // ----------------------------------------------------------------------
  // pair table
  // ----------------------------------------------------------------------
  logic [3:0] pair_a;
  logic [3:0] pair_b;
  logic       pair_bad;

  always_comb begin
    pair_bad = 1'b0;
    case (code_in)
      3'h0: begin pair_a = 4'h4; pair_b = 4'h5; end
      3'h1: begin pair_a = 4'h4; pair_b = 4'h6; end
      3'h2: begin pair_a = 4'h4; pair_b = 4'h7; end
      3'h3: begin pair_a = 4'h5; pair_b = 4'h6; end
      3'h4: begin pair_a = 4'h5; pair_b = 4'h7; end
      3'h5: begin pair_a = 4'h6; pair_b = 4'h7; end
      default: begin
        pair_a   = 4'h4;
        pair_b   = 4'h5;
        pair_bad = 1'b1;
      end
    endcase
  end

  wire logic [3:0] square_reg = PF_DST_BASE + {2'h0, code_in[1:0]};

  assign first_out   = square_in ? square_reg : pair_a;
  assign second_out  = square_in ? square_reg : pair_b;
  assign illegal_out = square_in ? code_in[2] : pair_bad;

endmodule : multiply_pair_decode
`default_nettype wire

// ---- hw/operand_field_decoder.sv ----
/* Operand field decoder: decodes operand fields, keeps status bits, has
   APB registers. Assumes one fetched word per valid cycle. */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RL1: size suffix decodes byte, word, double; default word
// RL2: accumulator field selects exactly A or B
// RL3: write-back goes to W13 or [W13]+=2 only
// RL4: 4-bit bit field selects one of sixteen bits
// RL5: file addresses span zero through 0x1FFF only
// RL6: immediate max 255 in byte mode, 1023 word
// RL7: program address immediate must be even
// RL8: keep carry, half carry, negative, overflow, sticky zero
// RL9: keep overflow and saturation bits per accumulator
// RL10: multiply pair is one of six W4-W7 pairings
// RL11: square uses one of W4-W7 for both
// RL12: X prefetch via W8/W9 modes, W9+W12, or none
// RL13: Y prefetch via W10/W11 modes, W11+W12, or none
// RL14: X prefetch destination is W4 through W7
// RL15: Y prefetch destination is W4 through W7
// RL16: working register field selects W0 through W15
// RL17: default working register is W0
// RL18: divide takes two directly addressed working registers
// RL19: word is 24 bits with 8-bit opcode
// RL20: second word has zero top byte; alone NOP
// RL21: flag illegal pairings and operand encodings
module operand_field_decoder
  import operand_decode_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  // instruction words from fetch
  input  wire logic                instr_valid_in,
  input  wire logic [INSTR_W-1:0]  instr_word_in,
  // status updates from the datapath
  input  wire logic [4:0]          arith_flag_we_in,
  input  wire logic [4:0]          arith_flag_in,
  input  wire logic                sticky_zero_in,
  input  wire logic [3:0]          dsp_flag_we_in,
  input  wire logic [3:0]          dsp_flag_in,
  // apb slave
  input  wire logic                psel_in,
  input  wire logic                penable_in,
  input  wire logic                pwrite_in,
  input  wire logic [ADDR_W-1:0]   paddr_in,
  input  wire logic [31:0]         pwdata_in,
  output logic                     pready_out,
  output logic [31:0]              prdata_out,
  output logic                     pslverr_out,
  // decoded selects to the datapath
  output logic                     dec_valid_out,
  output logic                     exec_enable_out,
  output logic                     illegal_out,
  output instr_class_t             instr_class_out,
  output logic [1:0]               op_size_out,
  output logic                     acc_select_out,
  output logic [3:0]               base_register_out,
  output logic [3:0]               source_operand_out,
  output logic [3:0]               destination_operand_out,
  output logic [12:0]              file_addr_out,
  output logic                     default_work_register_out,
  output logic [22:0]              immediate_out,
  output logic [15:0]              bit_mask_out,
  output logic                     x_prefetch_en_out,
  output logic [3:0]               x_prefetch_pointer_out,
  output logic [3:0]               x_prefetch_mod_out,
  output logic                     x_prefetch_indexed_out,
  output logic [3:0]               x_prefetch_dest_out,
  output logic                     y_prefetch_en_out,
  output logic [3:0]               y_prefetch_pointer_out,
  output logic [3:0]               y_prefetch_mod_out,
  output logic                     y_prefetch_indexed_out,
  output logic [3:0]               y_prefetch_dest_out,
  output logic                     writeback_en_out,
  output logic                     writeback_post_inc_out,
  output logic [3:0]               writeback_pointer_out,
  output logic [4:0]               arith_flags_out,
  output logic [3:0]               dsp_flags_out
);

  // --------------------
  // helpers
  // --------------------
  function automatic logic size_bad(input logic [1:0] sz);
    size_bad = (sz != SZ_WORD) && (sz != SZ_BYTE) && (sz != SZ_DOUBLE);
  endfunction : size_bad

  function automatic logic [15:0] one_hot16(input logic [3:0] pos);
    one_hot16 = 16'h0001 << pos;
  endfunction : one_hot16

  typedef enum logic {ST_FIRST, ST_SECOND} word_state_t;

  // --------------------
  // field extraction
  // --------------------
  wire logic [7:0]  opcode   = instr_word_in[OPC_MSB:OPC_LSB]; // RL19
  wire logic [15:0] operand  = instr_word_in[15:0];
  wire logic [1:0]  size_fld = instr_word_in[SIZE_MSB:SIZE_LSB]; // RL1
  wire logic [9:0]  ten_bit_immediate = instr_word_in[TEN_BIT_IMMEDIATE_MSB:TEN_BIT_IMMEDIATE_LSB];
  wire logic [3:0]  bit_position_field = instr_word_in[BITPOS_MSB:BITPOS_LSB];
  wire logic [2:0]  pair_fld = instr_word_in[PAIR_MSB:PAIR_LSB];
  wire logic [3:0]  xpf_fld  = instr_word_in[XPF_MSB:XPF_LSB];
  wire logic [3:0]  ypf_fld  = instr_word_in[YPF_MSB:YPF_LSB];
  wire logic [1:0]  xdst_fld = instr_word_in[XDST_MSB:XDST_LSB];
  wire logic [1:0]  ydst_fld = instr_word_in[YDST_MSB:YDST_LSB];
  wire logic        is_mac   = (opcode[7:2] == OP_MAC6);
  wire logic        is_sqr   = (opcode[7:2] == OP_SQR6);

  // --------------------
  // sub-decoders
  // --------------------
  logic [3:0] mul_first, mul_second;
  logic       mul_bad;

  multiply_pair_decode u_pair (
    .code_in     (pair_fld),
    .square_in   (is_sqr),
    .first_out   (mul_first),
    .second_out  (mul_second),
    .illegal_out (mul_bad)
  ); // RL10 RL11

  logic       xpf_en, xpf_idx, ypf_en, ypf_idx;
  logic [3:0] xpf_ptr, xpf_mod, ypf_ptr, ypf_mod;

  prefetch_mode_decode #(.BASE_REG(XPF_BASE)) u_xpf (
    .code_in      (xpf_fld),
    .enable_out   (xpf_en),
    .pointer_out  (xpf_ptr),
    .modifier_out (xpf_mod),
    .indexed_out  (xpf_idx)
  ); // RL12

  prefetch_mode_decode #(.BASE_REG(YPF_BASE)) u_ypf (
    .code_in      (ypf_fld),
    .enable_out   (ypf_en),
    .pointer_out  (ypf_ptr),
    .modifier_out (ypf_mod),
    .indexed_out  (ypf_idx)
  ); // RL13

  // --------------------
  // class and legality of a first word
  // --------------------
  instr_class_t cls;
  logic         first_bad;

  always_comb begin
    first_bad = 1'b0;
    case (opcode)
      OP_NOP:   cls = CLS_NOP; // RL20
      OP_FILE:  cls = CLS_FILE;
      OP_TEN_BIT_IMMEDIATE: cls = CLS_TEN_BIT_IMMEDIATE;
      OP_BIT:   cls = CLS_BIT;
      OP_REG3:  cls = CLS_REG3;
      OP_DIV:   cls = CLS_DIV;
      OP_GOTO:  cls = CLS_GOTO;
      default:  cls = is_mac ? CLS_MAC : (is_sqr ? CLS_SQR : CLS_UNKNOWN);
    endcase
    case (cls)
      CLS_FILE, CLS_REG3: first_bad = size_bad(size_fld); // RL1
      CLS_TEN_BIT_IMMEDIATE: first_bad = size_bad(size_fld) ||
        (size_fld == SZ_BYTE && ten_bit_immediate > TEN_BIT_IMMEDIATE_BYTE_MAX); // RL6
      CLS_GOTO:  first_bad = operand[0]; // RL7
      CLS_MAC, CLS_SQR: first_bad = mul_bad; // RL21
      CLS_UNKNOWN: first_bad = 1'b1; // RL21
      default:   first_bad = 1'b0;
    endcase
  end

  wire logic sized_cls = (cls == CLS_FILE) || (cls == CLS_TEN_BIT_IMMEDIATE) ||
                         (cls == CLS_REG3);
  wire logic dsp_cls   = (cls == CLS_MAC) || (cls == CLS_SQR);

  // --------------------
  // two-word sequencing
  // --------------------
  word_state_t state_reg;
  word_state_t state_next;
  logic [15:0] low_word_reg;

  wire logic first_take  = instr_valid_in && (state_reg == ST_FIRST);
  wire logic second_take = instr_valid_in && (state_reg == ST_SECOND);
  wire logic second_bad  = (opcode != OP_NOP); // RL20
  wire logic start_long  = first_take && (cls == CLS_GOTO);

  always_comb begin
    case (state_reg)
      ST_FIRST:  state_next = start_long ? ST_SECOND : ST_FIRST;
      ST_SECOND: state_next = instr_valid_in ? ST_FIRST : ST_SECOND;
      default:   state_next = ST_FIRST;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg    <= ST_FIRST;
      low_word_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      if (start_long) begin
        low_word_reg <= operand;
      end
    end
  end

  // --------------------
  // decoded result, next values
  // --------------------
  wire logic emit_next = (first_take && !start_long) || second_take;
  wire logic bad_next  = second_take ? (second_bad || low_word_reg[0])
                                     : first_bad;
  wire logic [1:0] size_next = sized_cls ? size_fld : SZ_WORD; // RL1
  wire logic [3:0] base_next =
    (cls == CLS_DIV) ? operand[7:4] :                     // RL18
    dsp_cls          ? mul_first    : operand[11:8];     // RL16
  wire logic [3:0] src_next =
    dsp_cls ? mul_second : operand[7:4];                  // RL10 RL11
  wire logic [3:0] dst_next =
    (cls == CLS_FILE && operand[FILE_DEFAULT_WORK_REGISTER]) ? DEFAULT_WORK_REGISTER_DEFAULT : // RL17
    operand[3:0];                                            // RL16
  wire logic [12:0] file_next = operand[FILE_MSB:0] & FILE_ADDR_MAX; // RL5
  wire logic [22:0] imm_next =
    second_take ? {operand[SECOND_HI_W-1:0], low_word_reg} : // RL7
    {13'h0000, ten_bit_immediate};
  wire logic [15:0] mask_next = one_hot16(bit_position_field); // RL4

  // --------------------
  // decoded result registers
  // --------------------
  logic [0:0] ctrl_reg;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dec_valid_out             <= 1'b0;
      illegal_out               <= 1'b0;
      instr_class_out           <= CLS_NOP;
      op_size_out               <= SZ_WORD;
      acc_select_out            <= 1'b0;
      base_register_out         <= 4'h0;
      source_operand_out        <= 4'h0;
      destination_operand_out   <= 4'h0;
      file_addr_out             <= 13'h0000;
      default_work_register_out <= 1'b0;
      immediate_out             <= 23'h00_0000;
      bit_mask_out              <= 16'h0000;
      x_prefetch_en_out         <= 1'b0;
      x_prefetch_pointer_out    <= 4'h0;
      x_prefetch_mod_out        <= 4'h0;
      x_prefetch_indexed_out    <= 1'b0;
      x_prefetch_dest_out       <= 4'h0;
      y_prefetch_en_out         <= 1'b0;
      y_prefetch_pointer_out    <= 4'h0;
      y_prefetch_mod_out        <= 4'h0;
      y_prefetch_indexed_out    <= 1'b0;
      y_prefetch_dest_out       <= 4'h0;
      writeback_en_out          <= 1'b0;
      writeback_post_inc_out    <= 1'b0;
      writeback_pointer_out     <= 4'h0;
    end else begin
      dec_valid_out <= emit_next;
      if (emit_next) begin
        illegal_out               <= bad_next; // RL21
        instr_class_out           <= second_take ? CLS_GOTO : cls;
        op_size_out               <= size_next;
        acc_select_out            <= opcode[0] && dsp_cls; // RL2
        base_register_out         <= base_next;
        source_operand_out        <= src_next;
        destination_operand_out   <= dst_next;
        file_addr_out             <= file_next;
        default_work_register_out <= (cls == CLS_FILE) && operand[FILE_DEFAULT_WORK_REGISTER];
        immediate_out             <= imm_next;
        bit_mask_out              <= mask_next;
        x_prefetch_en_out         <= xpf_en && dsp_cls; // RL12
        x_prefetch_pointer_out    <= xpf_ptr;
        x_prefetch_mod_out        <= xpf_mod;
        x_prefetch_indexed_out    <= xpf_idx;
        x_prefetch_dest_out       <= PF_DST_BASE + {2'h0, xdst_fld}; // RL14
        y_prefetch_en_out         <= ypf_en && dsp_cls; // RL13
        y_prefetch_pointer_out    <= ypf_ptr;
        y_prefetch_mod_out        <= ypf_mod;
        y_prefetch_indexed_out    <= ypf_idx;
        y_prefetch_dest_out       <= PF_DST_BASE + {2'h0, ydst_fld}; // RL15
        writeback_en_out          <= opcode[1] && (cls == CLS_MAC); // RL3
        writeback_post_inc_out    <= operand[AWB_MODE]; // RL3
        writeback_pointer_out     <= WB_REG; // RL3
      end
    end
  end

  assign exec_enable_out = dec_valid_out &&
                           !(illegal_out && ctrl_reg[CTRL_BLOCK]); // RL21

  // --------------------
  // core and dsp status bits
  // --------------------
  // zero bit in sticky mode can only be cleared, never set
  wire logic zero_next = sticky_zero_in ? (arith_flags_out[4] &&
                         arith_flag_in[4]) : arith_flag_in[4];
  wire logic [4:0] arith_new = {zero_next, arith_flag_in[3:0]};

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      arith_flags_out <= ARITH_RESET;
      dsp_flags_out   <= DSP_RESET;
    end else begin
      arith_flags_out <= (arith_flag_we_in & arith_new) |
                         (~arith_flag_we_in & arith_flags_out); // RL8
      dsp_flags_out   <= (dsp_flag_we_in & dsp_flag_in) |
                         (~dsp_flag_we_in & dsp_flags_out); // RL9
    end
  end

  // --------------------
  // apb registers
  // --------------------
  logic        illegal_seen_reg;
  logic [23:0] last_bad_reg, last_word_reg;

  wire logic setup    = psel_in && !penable_in;
  wire logic access   = psel_in && penable_in;
  wire logic hit_ctrl = (paddr_in == ADDR_W'(CTRL_OFS));
  wire logic hit_stat = (paddr_in == ADDR_W'(STATUS_OFS));
  wire logic hit_last = (paddr_in == ADDR_W'(LAST_BAD_OFS));
  wire logic hit_any  = hit_ctrl || hit_stat || hit_last;
  wire logic wr_ctrl  = access && pwrite_in && hit_ctrl;
  wire logic clr_ill  = access && pwrite_in && hit_stat &&
                        pwdata_in[ST_ILLEGAL];
  wire logic ill_evt  = dec_valid_out && illegal_out;
  wire logic [31:0] status_word = {15'h0000, illegal_seen_reg, 7'h00,
                                   dsp_flags_out, arith_flags_out};
  wire logic [31:0] read_mux =
    hit_ctrl ? {31'h0000_0000, ctrl_reg} :
    hit_stat ? status_word :
    hit_last ? {8'h00, last_bad_reg} : 32'h0000_0000;

  assign pready_out = 1'b1;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_reg         <= CTRL_RESET;
      illegal_seen_reg <= 1'b0;
      last_word_reg    <= 24'h00_0000;
      last_bad_reg     <= 24'h00_0000;
      prdata_out       <= 32'h0000_0000;
      pslverr_out      <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= pwdata_in[CTRL_BLOCK:CTRL_BLOCK];
      end
      // a new illegal event wins over a same-cycle clear
      illegal_seen_reg <= ill_evt || (illegal_seen_reg && !clr_ill);
      if (emit_next) begin
        last_word_reg <= instr_word_in;
      end
      if (ill_evt) begin
        last_bad_reg <= last_word_reg;
      end
      if (setup) begin
        prdata_out  <= pwrite_in ? 32'h0000_0000 : read_mux;
        pslverr_out <= !hit_any;
      end
    end
  end

endmodule : operand_field_decoder
`default_nettype wire

// ---- hw/prefetch_mode_decode.sv ----
/*
  Decodes one 4-bit prefetch address field into pointer register,
  post-access modifier, indexed flag and enable.
  Assumes BASE_REG names the lower of the two usable pointer registers.
*/
`timescale 1ns/1ps
`default_nettype none

module prefetch_mode_decode
  import operand_decode_pkg::*;
#(
  parameter logic [3:0] BASE_REG = XPF_BASE
) (
  input  wire logic [3:0] code_in,
  output logic            enable_out,
  output logic [3:0]      pointer_out,
  output logic [3:0]      modifier_out,
  output logic            indexed_out
);

  // ----------------------------------------------------------------------
  // field split
  // ----------------------------------------------------------------------
  wire logic       upper_reg = code_in[3];
  wire logic [2:0] mode      = code_in[2:0];
  wire logic       alt_mode  = (mode == PF_MODE_ALT);

  // alternate mode is "no prefetch" on the lower pointer and indexed by
  // the index register on the upper one; modifier is twice the mode,
  // which gives +2/+4/+6 and -6/-4/-2 in two's complement
  assign enable_out   = !(alt_mode && !upper_reg);
  assign pointer_out  = BASE_REG + {3'h0, upper_reg};
  assign indexed_out  = alt_mode && upper_reg;
  assign modifier_out = alt_mode ? 4'h0 : {mode, 1'b0};

endmodule : prefetch_mode_decode
`default_nettype wire
